// ---- rtl/apt_pkg.sv ----
package apt_pkg;

    // ====================
    // register bus
    localparam int AXI_AW = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_TRIG_EN = 8'h08;
    localparam logic [7:0] OFF_EVENTS = 8'h0C;
    localparam logic [7:0] OFF_INT_STAT = 8'h10;
    localparam logic [7:0] OFF_INT_MASK = 8'h14;
    localparam logic [7:0] OFF_PROBES = 8'h18;
    localparam logic [7:0] OFF_STAGE = 8'h20;
    localparam logic [7:0] OFF_OUTV = 8'h30;
    localparam logic [7:0] OFF_INV = 8'h40;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ====================
    // field layouts
    localparam int CTRL_COMMIT = 0;
    localparam int CTRL_REFRESH = 1;
    localparam int CTRL_PULL = 2;
    localparam int ST_AT_RESET = 0;
    localparam int ST_OUT_OF_SYNC = 1;
    localparam int ST_BUSY = 2;
    localparam int VALID_BIT = 0;
    localparam int READY_BIT = 1;
    localparam int LAST_BIT = 2;
    localparam int ADDR_CH_W = 2;
    localparam int DATA_CH_W = 3;
    localparam int PROBE_ALL_W = 12;
    localparam logic [1:0] ADDR_DONE_PAT = 2'h3;
    localparam logic [2:0] DATA_LAST_PAT = 3'h7;
    localparam logic [2:0] DATA_BEAT_PAT = 3'h3;

    // event vector positions
    localparam int EV_AR = 0;
    localparam int EV_R_BEAT = 1;
    localparam int EV_R_LAST = 2;
    localparam int EV_AW = 3;
    localparam int EV_W_BEAT = 4;
    localparam int EV_W_LAST = 5;
    localparam int EV_B = 6;
    localparam int EV_TRIG = 7;
    localparam int EV_SRC_N = 7;
    localparam int EV_N = 8;

    // ====================
    // virtual i/o sizes and reset values
    localparam int VIO_OUT_WORDS = 4;
    localparam int VIO_IN_WORDS = 2;
    localparam int IDX_W = 2;
    localparam logic [IDX_W-1:0] IDX_LAST = 2'h3;
    localparam logic [DATA_W-1:0] VIO_WORD_RST = 32'h0000_0000;
    localparam logic [EV_SRC_N-1:0] TRIG_EN_RST = 7'h00;
    localparam logic [EV_N-1:0] INT_MASK_RST = 8'h00;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_MEM = 2'b01,
        RD_LOAD = 2'b10,
        RD_RESP = 2'b11
    } apt_rd_state_t;

    typedef enum logic [2:0] {
        SQ_IDLE = 3'b000,
        SQ_COMMIT = 3'b001,
        SQ_DRAIN = 3'b010,
        SQ_APPLY = 3'b011,
        SQ_PULL = 3'b100
    } apt_seq_state_t;

endpackage

// ---- rtl/apt_chan_probe.sv ----
`timescale 1ns/1ps
module apt_chan_probe import apt_pkg::*; #(
    parameter int W = 2,
    parameter logic [W-1:0] FINAL_PAT = '1,
    parameter logic [W-1:0] BEAT_PAT = '1,
    parameter bit HAS_BEAT = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic chValid,
    input wire logic chReady,
    input wire logic chLast,
    output logic [W-1:0] probe,
    output logic evFinal,
    output logic evBeat
);

    logic [W-1:0] next_probe;
    logic [DATA_CH_W-1:0] packed3;

    // ==========================================================
    // packing: valid low, ready above, last on top
    assign packed3 = {chLast, chReady, chValid};
    assign next_probe = packed3[W-1:0];

    // compares run on the unregistered inputs; results register together with the probe
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            probe <= '0;
            evFinal <= 1'b0;
            evBeat <= 1'b0;
        end else begin
            probe <= next_probe;
            evFinal <= (next_probe == FINAL_PAT);
            evBeat <= HAS_BEAT && (next_probe == BEAT_PAT);
        end
    end

endmodule

// ---- rtl/apt_word_mem.sv ----
`timescale 1ns/1ps
module apt_word_mem import apt_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wrEn,
    input wire logic [IDX_W-1:0] wrIdx,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic [3:0] wrBe,
    input wire logic [IDX_W-1:0] rdIdx,
    output logic [DATA_W-1:0] rdData
);

    logic [DATA_W-1:0] mem [VIO_OUT_WORDS];

    // ==========================================================
    // staged words start equal to the output reset values
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < VIO_OUT_WORDS; i++) begin
                mem[i] <= VIO_WORD_RST;
            end
            rdData <= VIO_WORD_RST;
        end else begin
            if (wrEn) begin
                for (int b = 0; b < 4; b++) begin
                    if (wrBe[b]) begin
                        mem[wrIdx][8*b +: 8] <= wrData[8*b +: 8];
                    end
                end
            end
            rdData <= mem[rdIdx];
        end
    end

endmodule

// ---- rtl/apt_debug_top.sv ----
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
module apt_debug_top import apt_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic monArvalid,
    input wire logic monArready,
    input wire logic monRvalid,
    input wire logic monRready,
    input wire logic monRlast,
    input wire logic monAwvalid,
    input wire logic monAwready,
    input wire logic monWvalid,
    input wire logic monWready,
    input wire logic monWlast,
    input wire logic monBvalid,
    input wire logic monBready,
    output logic [ADDR_CH_W-1:0] read_addr_ctl_probe,
    output logic [DATA_CH_W-1:0] readDataCtlProbe,
    output logic [ADDR_CH_W-1:0] write_addr_ctl_probe,
    output logic [DATA_CH_W-1:0] writeDataCtlProbe,
    output logic [ADDR_CH_W-1:0] writeRespCtlProbe,
    output logic [EV_SRC_N-1:0] eventFlags,
    output logic readAddrCmdActive,
    output logic writeAddrCmdActive,
    output logic triggerOut,
    input wire logic [DATA_W*VIO_IN_WORDS-1:0] vioInProbes,
    output logic [DATA_W*VIO_OUT_WORDS-1:0] vioOutProbes,
    output logic irq
);

    // ==========================================================
    // helpers
    function automatic logic regionIs(input logic [AXI_AW-1:0] a, input logic [AXI_AW-1:0] b);
        return a[AXI_AW-1:4] == b[AXI_AW-1:4];
    endfunction

    function automatic logic [IDX_W-1:0] wordIdx(input logic [AXI_AW-1:0] a);
        return a[IDX_W+1:2];
    endfunction

    localparam logic [DATA_W*VIO_OUT_WORDS-1:0] VIO_OUT_RST = {VIO_OUT_WORDS{VIO_WORD_RST}};
    // ====================
    // channel probes
    logic evArDone, evRLast, evRBeat, evAwDone, evWLast, evWBeat, evBDone;
    apt_chan_probe #(.W(ADDR_CH_W), .FINAL_PAT(ADDR_DONE_PAT)) uArProbe (
        .clk_sys(clk_sys), .rst(rst), .chValid(monArvalid), .chReady(monArready),
        .chLast(1'b0), .probe(read_addr_ctl_probe), .evFinal(evArDone), .evBeat());
    apt_chan_probe #(.W(DATA_CH_W), .FINAL_PAT(DATA_LAST_PAT), .BEAT_PAT(DATA_BEAT_PAT),
        .HAS_BEAT(1'b1)) uRProbe (
        .clk_sys(clk_sys), .rst(rst), .chValid(monRvalid), .chReady(monRready),
        .chLast(monRlast), .probe(readDataCtlProbe), .evFinal(evRLast),
        .evBeat(evRBeat));
    apt_chan_probe #(.W(ADDR_CH_W), .FINAL_PAT(ADDR_DONE_PAT)) uAwProbe (
        .clk_sys(clk_sys), .rst(rst), .chValid(monAwvalid), .chReady(monAwready),
        .chLast(1'b0), .probe(write_addr_ctl_probe), .evFinal(evAwDone), .evBeat());
    apt_chan_probe #(.W(DATA_CH_W), .FINAL_PAT(DATA_LAST_PAT), .BEAT_PAT(DATA_BEAT_PAT),
        .HAS_BEAT(1'b1)) uWProbe (
        .clk_sys(clk_sys), .rst(rst), .chValid(monWvalid), .chReady(monWready),
        .chLast(monWlast), .probe(writeDataCtlProbe), .evFinal(evWLast),
        .evBeat(evWBeat));
    apt_chan_probe #(.W(ADDR_CH_W), .FINAL_PAT(ADDR_DONE_PAT)) uBProbe (
        .clk_sys(clk_sys), .rst(rst), .chValid(monBvalid), .chReady(monBready),
        .chLast(1'b0), .probe(writeRespCtlProbe), .evFinal(evBDone), .evBeat());

    always_comb begin
        eventFlags = '0;
        eventFlags[EV_AR] = evArDone;
        eventFlags[EV_R_BEAT] = evRBeat;
        eventFlags[EV_R_LAST] = evRLast;
        eventFlags[EV_AW] = evAwDone;
        eventFlags[EV_W_BEAT] = evWBeat;
        eventFlags[EV_W_LAST] = evWLast;
        eventFlags[EV_B] = evBDone;
    end

    // command spans valid high up to its handshake cycle
    assign readAddrCmdActive = read_addr_ctl_probe[VALID_BIT];
    assign writeAddrCmdActive = write_addr_ctl_probe[VALID_BIT];

    wire [PROBE_ALL_W-1:0] probeAll = {writeRespCtlProbe, writeDataCtlProbe,
        write_addr_ctl_probe, readDataCtlProbe, read_addr_ctl_probe};

    // ====================
    // write channel of the register bus
    logic awHeld, wHeld;
    logic [AXI_AW-1:0] awAddrQ;
    logic [DATA_W-1:0] wDataQ;
    logic [3:0] wStrbQ;
    logic seqBusy;

    assign s_axi_awready = !awHeld;
    assign s_axi_wready = !wHeld;

    // writes wait while the commit or read-back walk owns the staging memory
    wire doWrite = awHeld && wHeld && !s_axi_bvalid && !seqBusy;
    wire wLow = doWrite && wStrbQ[0];
    wire wrCtrl = wLow && (awAddrQ == OFF_CTRL);
    wire wrTrig = wLow && (awAddrQ == OFF_TRIG_EN);
    wire wrStat = wLow && (awAddrQ == OFF_INT_STAT);
    wire wrMask = wLow && (awAddrQ == OFF_INT_MASK);
    wire wrStage = doWrite && regionIs(awAddrQ, OFF_STAGE);
    wire wrKnown = (awAddrQ == OFF_CTRL) || (awAddrQ == OFF_STATUS) ||
        (awAddrQ == OFF_TRIG_EN) || (awAddrQ == OFF_EVENTS) ||
        (awAddrQ == OFF_INT_STAT) || (awAddrQ == OFF_INT_MASK) ||
        (awAddrQ == OFF_PROBES) || regionIs(awAddrQ, OFF_STAGE) ||
        regionIs(awAddrQ, OFF_OUTV) || (regionIs(awAddrQ, OFF_INV) && !awAddrQ[3]);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrQ <= '0;
            wDataQ <= '0;
            wStrbQ <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddrQ <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrKnown ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ====================
    // trigger and interrupt
    logic [EV_SRC_N-1:0] trigEn;
    logic [EV_N-1:0] intStat, intMask;
    wire [EV_N-1:0] evAll = {triggerOut, eventFlags};
    wire [EV_N-1:0] intClr = wrStat ? wDataQ[EV_N-1:0] : '0;

    assign irq = |(intStat & intMask);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            trigEn <= TRIG_EN_RST;
            intMask <= INT_MASK_RST;
            intStat <= '0;
            triggerOut <= 1'b0;
        end else begin
            if (wrTrig) begin
                trigEn <= wDataQ[EV_SRC_N-1:0];
            end
            if (wrMask) begin
                intMask <= wDataQ[EV_N-1:0];
            end
            triggerOut <= |(eventFlags & trigEn);
            // a new event beats a clear in the same cycle
            intStat <= (intStat & ~intClr) | evAll;
        end
    end

    // ====================
    // virtual i/o: staging memory and commit / read-back walker
    apt_seq_state_t seqState, next_seqState;
    logic [IDX_W-1:0] seqIdx, seqRdIdx, rdIdx;
    logic seqRdValid, outOfSync;
    logic [DATA_W*VIO_OUT_WORDS-1:0] shadow;
    logic [DATA_W*VIO_IN_WORDS-1:0] vioInSample;
    logic [DATA_W-1:0] memRd;
    apt_rd_state_t rdState;
    logic [AXI_AW-1:0] rdAddr;

    assign seqBusy = (seqState != SQ_IDLE);
    wire pulling = (seqState == SQ_PULL);
    wire seqLast = (seqIdx == IDX_LAST);
    wire [DATA_W-1:0] pullWord = vioOutProbes[DATA_W*int'(seqIdx) +: DATA_W];
    wire memWrEn = pulling || wrStage;
    wire [IDX_W-1:0] memWrIdx = pulling ? seqIdx : wordIdx(awAddrQ);
    wire [DATA_W-1:0] memWrData = pulling ? pullWord : wDataQ;
    wire [3:0] memWrBe = pulling ? 4'hF : wStrbQ;
    wire [IDX_W-1:0] memRdIdx = seqBusy ? seqIdx : rdIdx;

    // staged values live here until a commit
    apt_word_mem uStage (
        .clk_sys(clk_sys), .rst(rst), .wrEn(memWrEn), .wrIdx(memWrIdx),
        .wrData(memWrData), .wrBe(memWrBe), .rdIdx(memRdIdx), .rdData(memRd));

    always_comb begin
        next_seqState = seqState;
        case (seqState)
            SQ_IDLE: begin
                if (wrCtrl && wDataQ[CTRL_COMMIT]) begin
                    next_seqState = SQ_COMMIT;
                end else if (wrCtrl && wDataQ[CTRL_PULL]) begin
                    next_seqState = SQ_PULL;
                end
            end
            SQ_COMMIT: next_seqState = seqLast ? SQ_DRAIN : SQ_COMMIT;
            SQ_DRAIN: next_seqState = SQ_APPLY;
            SQ_APPLY: next_seqState = SQ_IDLE;
            SQ_PULL: next_seqState = seqLast ? SQ_IDLE : SQ_PULL;
            default: next_seqState = SQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            seqState <= SQ_IDLE;
            seqIdx <= '0;
            seqRdValid <= 1'b0;
            seqRdIdx <= '0;
            shadow <= VIO_OUT_RST;
            vioOutProbes <= VIO_OUT_RST;
            outOfSync <= 1'b0;
            vioInSample <= '0;
        end else begin
            seqState <= next_seqState;
            seqIdx <= (seqState == SQ_COMMIT || pulling) ? seqIdx + 1'b1 : '0;
            seqRdValid <= (seqState == SQ_COMMIT);
            seqRdIdx <= seqIdx;
            if (seqRdValid) begin
                shadow[DATA_W*int'(seqRdIdx) +: DATA_W] <= memRd;
            end
            // outputs change all at once, only on commit
            if (seqState == SQ_APPLY) begin
                vioOutProbes <= shadow;
            end
            // commit or read-back brings host copy and outputs together
            if (wrStage) begin
                outOfSync <= 1'b1;
            end else if (seqState == SQ_APPLY || (pulling && seqLast)) begin
                outOfSync <= 1'b0;
            end
            // refresh takes one snapshot of the inputs
            if (wrCtrl && wDataQ[CTRL_REFRESH]) begin
                vioInSample <= vioInProbes;
            end
        end
    end

    // outputs compared with their reset values
    wire atReset = (vioOutProbes == VIO_OUT_RST);

    // ====================
    // read channel of the register bus
    assign rdIdx = wordIdx(rdAddr);
    assign s_axi_arready = (rdState == RD_IDLE);
    assign s_axi_rvalid = (rdState == RD_RESP);

    logic [DATA_W-1:0] rdMux;
    logic rdHit;
    always_comb begin
        rdMux = '0;
        rdHit = 1'b1;
        if (rdAddr == OFF_CTRL) begin
            rdMux = '0;
        end else if (rdAddr == OFF_STATUS) begin
            rdMux[ST_AT_RESET] = atReset;
            rdMux[ST_OUT_OF_SYNC] = outOfSync;
            rdMux[ST_BUSY] = seqBusy;
        end else if (rdAddr == OFF_TRIG_EN) begin
            rdMux[EV_SRC_N-1:0] = trigEn;
        end else if (rdAddr == OFF_EVENTS) begin
            rdMux[EV_N-1:0] = evAll;
        end else if (rdAddr == OFF_INT_STAT) begin
            rdMux[EV_N-1:0] = intStat;
        end else if (rdAddr == OFF_INT_MASK) begin
            rdMux[EV_N-1:0] = intMask;
        end else if (rdAddr == OFF_PROBES) begin
            rdMux[PROBE_ALL_W-1:0] = probeAll;
        end else if (regionIs(rdAddr, OFF_STAGE)) begin
            rdMux = memRd;
        end else if (regionIs(rdAddr, OFF_OUTV)) begin
            rdMux = vioOutProbes[DATA_W*int'(rdIdx) +: DATA_W];
        end else if (regionIs(rdAddr, OFF_INV) && !rdAddr[3]) begin
            rdMux = vioInSample[DATA_W*int'(rdIdx[0]) +: DATA_W];
        end else begin
            rdHit = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdState <= RD_IDLE;
            rdAddr <= '0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            case (rdState)
                RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rdAddr <= s_axi_araddr;
                        rdState <= RD_MEM;
                    end
                end
                // memory read port is lent to the walker while it runs
                RD_MEM: begin
                    if (!seqBusy) begin
                        rdState <= RD_LOAD;
                    end
                end
                RD_LOAD: begin
                    s_axi_rdata <= rdMux;
                    s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
                    rdState <= RD_RESP;
                end
                RD_RESP: begin
                    if (s_axi_rready) begin
                        rdState <= RD_IDLE;
                    end
                end
                default: rdState <= RD_IDLE;
            endcase
        end
    end

endmodule

// ---- dv/apt_debug_props.sv ----
`timescale 1ns/1ps
module apt_debug_props import apt_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic monArvalid,
    input wire logic monArready,
    input wire logic monRvalid,
    input wire logic monRready,
    input wire logic monRlast,
    input wire logic monAwvalid,
    input wire logic monAwready,
    input wire logic monWvalid,
    input wire logic monWready,
    input wire logic monWlast,
    input wire logic monBvalid,
    input wire logic monBready,
    input wire logic [ADDR_CH_W-1:0] read_addr_ctl_probe,
    input wire logic [DATA_CH_W-1:0] readDataCtlProbe,
    input wire logic [ADDR_CH_W-1:0] write_addr_ctl_probe,
    input wire logic [DATA_CH_W-1:0] writeDataCtlProbe,
    input wire logic [ADDR_CH_W-1:0] writeRespCtlProbe,
    input wire logic [EV_SRC_N-1:0] eventFlags,
    input wire logic readAddrCmdActive,
    input wire logic triggerOut
);
    // ====================
    // history checks
    // past values mean nothing on the first edge after reset
    logic up;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            up <= 1'b0;
        end else begin
            up <= 1'b1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_ar_take;
        monArvalid && monArready;
    endsequence
    property p_arp; up |-> read_addr_ctl_probe == {$past(monArready), $past(monArvalid)}; endproperty
    a_arp: assert property (p_arp) else $error("read address probe wrong");
    property p_rp; up |-> readDataCtlProbe == {$past(monRlast), $past(monRready), $past(monRvalid)}; endproperty
    a_rp: assert property (p_rp) else $error("read data probe wrong");
    property p_awp; up |-> write_addr_ctl_probe == {$past(monAwready), $past(monAwvalid)}; endproperty
    a_awp: assert property (p_awp) else $error("write address probe wrong");
    property p_wp; up |-> writeDataCtlProbe == {$past(monWlast), $past(monWready), $past(monWvalid)}; endproperty
    a_wp: assert property (p_wp) else $error("write data probe wrong");
    property p_bp; up |-> writeRespCtlProbe == {$past(monBready), $past(monBvalid)}; endproperty
    a_bp: assert property (p_bp) else $error("write response probe wrong");
    property p_ar; s_ar_take |=> eventFlags[EV_AR] && readAddrCmdActive; endproperty
    a_ar: assert property (p_ar) else $error("read address event missing");
    property p_rev; eventFlags[EV_R_LAST:EV_R_BEAT] ==
        {readDataCtlProbe == DATA_LAST_PAT, readDataCtlProbe == DATA_BEAT_PAT}; endproperty
    a_rev: assert property (p_rev) else $error("read data event wrong");
    property p_wev; eventFlags[EV_B:EV_AW] == {writeRespCtlProbe == ADDR_DONE_PAT,
        writeDataCtlProbe == DATA_LAST_PAT, writeDataCtlProbe == DATA_BEAT_PAT,
        write_addr_ctl_probe == ADDR_DONE_PAT}; endproperty
    a_wev: assert property (p_wev) else $error("write side event wrong");
    property p_trg; up && triggerOut |-> $past(eventFlags) != '0; endproperty
    a_trg: assert property (p_trg) else $error("trigger without event");
endmodule
bind apt_debug_top apt_debug_props i_props (.*);

// ---- dv/apt_mon_model.sv ----
`timescale 1ns/1ps
module apt_mon_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic active,
    input wire logic slow,
    output logic [11:0] mon
);
    // ====================
    // monitored bus traffic; a valid holds until its ready
    logic [4:0] v, r;
    logic rl, wl;
    assign mon = {r[4], v[4], wl, r[3], v[3], r[2], v[2], rl, r[1], v[1], r[0], v[0]};
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            v <= '0;
            r <= '0;
            {rl, wl} <= 2'b00;
        end else begin
            for (int i = 0; i < 5; i++) begin
                r[i] <= slow ? ($urandom_range(3) == 0) : 1'($urandom);
                if (!v[i] || r[i]) v[i] <= active && 1'($urandom);
            end
            if (!v[1] || r[1]) rl <= 1'($urandom);
            if (!v[3] || r[3]) wl <= 1'($urandom);
        end
    end
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench import apt_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, actv = 0, slow = 0;
    logic awready, wready, bvalid, arready, rvalid, trig, irq, trigX = 0, trigSeen = 0, rAct, wAct;
    logic [1:0] bresp, rresp, arP, awP, bP;
    logic [2:0] rP, wP;
    logic [11:0] mon, smp = '0;
    logic [6:0] evs, trigEn = '0;
    logic [63:0] vin = '0;
    logic [127:0] vout;
    int fail_count = 0, num_checks = 0;
    apt_mon_model i_mon (.clk_sys(clk_sys), .rst(rst), .active(actv), .slow(slow), .mon(mon));
    apt_debug_top i_dut (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .monArvalid(mon[0]), .monArready(mon[1]), .monRvalid(mon[2]),
        .monRready(mon[3]), .monRlast(mon[4]), .monAwvalid(mon[5]), .monAwready(mon[6]),
        .monWvalid(mon[7]), .monWready(mon[8]), .monWlast(mon[9]), .monBvalid(mon[10]),
        .monBready(mon[11]), .read_addr_ctl_probe(arP), .readDataCtlProbe(rP),
        .write_addr_ctl_probe(awP), .writeDataCtlProbe(wP), .writeRespCtlProbe(bP),
        .eventFlags(evs), .readAddrCmdActive(rAct), .writeAddrCmdActive(wAct), .triggerOut(trig),
        .vioInProbes(vin), .vioOutProbes(vout), .irq(irq));
    // ====================
    // reference model and checks
    initial forever #20 clk_sys = ~clk_sys;
    function automatic logic [6:0] ev(input logic [11:0] s);
        return {s[11:10] == 2'h3, s[9:7] == 3'h7, s[9:7] == 3'h3, s[6:5] == 2'h3,
            s[4:2] == 3'h7, s[4:2] == 3'h3, s[1:0] == 2'h3};
    endfunction
    task automatic chk(input string n, input logic [127:0] e, g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        smp <= rst ? '0 : mon;
        trigX <= !rst && |(ev(smp) & trigEn);
        if (trigX) trigSeen <= 1'b1;
    end
    always @(negedge clk_sys) begin
        if (!rst) begin
            chk("probes", smp, {bP, wP, awP, rP, arP});
            chk("events", ev(smp), evs);
            chk("active", {smp[5], smp[0]}, {wAct, rAct});
            chk("trigger", trigX, trig);
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        @(posedge clk_sys);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(negedge clk_sys);
            {ta, tw, tb} = {awready & awvalid, wready & wvalid, bvalid};
            if (tb) chk("bresp", er, bresp);
            @(posedge clk_sys);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        logic ta, tr;
        @(posedge clk_sys);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(negedge clk_sys);
            {ta, tr, d} = {arready & arvalid, rvalid, rdata};
            if (tr) chk("rresp", er, rresp);
            @(posedge clk_sys);
            if (ta) arvalid <= 1'b0;
        end while (!tr);
        rready <= 1'b0;
    endtask
    task automatic act(input logic [31:0] c, output logic [31:0] d);
        int n;
        wr(OFF_CTRL, c, RESP_OKAY);
        n = 0;
        do begin
            rd(OFF_STATUS, d, RESP_OKAY);
            n++;
        end while (d[ST_BUSY] && n < 20);
        chk("busy", 1'b0, d[ST_BUSY]);
    endtask
    initial begin
        logic [31:0] d, st[4];
        logic [63:0] smpIn;
        d = $urandom(32'h60B2042E);
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        rd(OFF_STATUS, d, RESP_OKAY);
        chk("status", 32'h1, d);
        for (int m = 0; m < 2; m++) begin
            {actv, slow} <= {1'b1, m[0]};
            repeat (200) @(posedge clk_sys);
        end
        actv <= 1'b0;
        repeat (60) @(posedge clk_sys);
        $display("monitor test done");
        wr(OFF_TRIG_EN, 32'h9, RESP_OKAY);
        repeat (3) @(posedge clk_sys);
        trigEn = 7'h09;
        actv <= 1'b1;
        repeat (100) @(posedge clk_sys);
        actv <= 1'b0;
        repeat (60) @(negedge clk_sys);
        chk("irq masked", 1'b0, irq);
        rd(OFF_INT_STAT, d, RESP_OKAY);
        chk("trigger status", trigSeen, d[EV_TRIG]);
        wr(OFF_INT_MASK, 32'h80, RESP_OKAY);
        @(negedge clk_sys);
        chk("irq", trigSeen, irq);
        wr(OFF_INT_STAT, 32'hFF, RESP_OKAY);
        @(negedge clk_sys);
        chk("irq cleared", 1'b0, irq);
        $display("trigger test done");
        for (int i = 0; i < 4; i++) begin
            st[i] = $urandom;
            wr(OFF_STAGE + 8'(4 * i), st[i], RESP_OKAY);
        end
        rd(OFF_STATUS, d, RESP_OKAY);
        chk("staged status", 32'h3, d);
        chk("outputs before commit", '0, vout);
        act(32'h1, d);
        chk("commit status", 32'h0, d);
        chk("outputs", {st[3], st[2], st[1], st[0]}, vout);
        wr(OFF_STAGE, ~st[0], RESP_OKAY);
        act(32'h4, d);
        chk("pull status", 32'h0, d);
        rd(OFF_STAGE, d, RESP_OKAY);
        chk("pulled word", st[0], d);
        rd(OFF_OUTV + 8'h4, d, RESP_OKAY);
        chk("output word", st[1], d);
        smpIn = {$urandom, $urandom};
        vin <= smpIn;
        wr(OFF_CTRL, 32'h2, RESP_OKAY);
        vin <= ~smpIn;
        for (int i = 0; i < 2; i++) begin
            rd(OFF_INV + 8'(4 * i), d, RESP_OKAY);
            chk("input sample", smpIn[32 * i +: 32], d);
        end
        rd(8'h50, d, RESP_SLVERR);
        chk("unmapped read", 32'h0, d);
        wr(8'h50, 32'h1, RESP_SLVERR);
        $display("virtual io test done");
        final_report();
    end
    initial begin
        #(10000 * 40);
        fail_count++;
        final_report();
    end
endmodule
